// ---- pkg/fcb_pkg.sv ----
// constants and types of the channel b equalizer coefficient bank
package fcb_pkg;

	// ------------------------------------------------
	// register port geometry
	// ------------------------------------------------
	localparam int FCB_ADDR_W = 15;
	localparam int FCB_DATA_W = 8;
	localparam logic [14:0] FCB_BYTE_STEP = 15'h0001;

	// ------------------------------------------------
	// register byte addresses, low byte of each register
	// ------------------------------------------------
	localparam logic [14:0] FCB_ADDR_TAP3 = 15'h044C;
	localparam logic [14:0] FCB_ADDR_TAP4 = 15'h044E;
	localparam logic [14:0] FCB_ADDR_CENTRE = 15'h0450;
	localparam logic [14:0] FCB_ADDR_TAP6 = 15'h0453;
	localparam logic [14:0] FCB_ADDR_TAP7 = 15'h0455;
	localparam logic [14:0] FCB_ADDR_TAP8 = 15'h0457;

	// ------------------------------------------------
	// field positions and widths
	// ------------------------------------------------
	localparam int FCB_TAP_MSB = 11;
	localparam int FCB_TAP_W = 12;
	localparam int FCB_RSV16_LSB = 12;
	localparam int FCB_CENTRE_MSB = 17;
	localparam int FCB_CENTRE_W = 18;
	localparam int FCB_RSV24_LSB = 18;
	localparam int FCB_NUM_TAPS = 9;
	localparam int FCB_CENTRE_TAP = 5;

	// ------------------------------------------------
	// reset values
	// ------------------------------------------------
	localparam logic [15:0] FCB_RST_REG16 = 16'h0000;
	localparam logic [23:0] FCB_RST_REG24 = 24'h00_0000;
	localparam logic [7:0] FCB_RST_BYTE = 8'h00;

	// ------------------------------------------------
	// types
	// ------------------------------------------------
	typedef struct packed {
		logic [15:0] tap3;
		logic [15:0] tap4;
		logic [23:0] centre;
		logic [15:0] tap6;
		logic [15:0] tap7;
		logic [15:0] tap8;
	} fcb_regs_t;

	typedef struct packed {
		logic signed [11:0] tap3;
		logic signed [11:0] tap4;
		logic signed [17:0] centre;
		logic signed [11:0] tap6;
		logic signed [11:0] tap7;
		logic signed [11:0] tap8;
	} fcb_coef_t;

	typedef struct packed {
		fcb_regs_t regs;
		logic [7:0] rdata;
		logic rvalid;
	} fcb_state_t;

	typedef struct packed {
		fcb_coef_t coef;
		logic active;
	} fcb_apply_state_t;

endpackage

// ---- verilog/fcb_coef_apply.sv ----
// coefficient hand-over from register bank to the sample-rate filter
`timescale 1ns/100ps
module fcb_coef_apply (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire fcb_pkg::fcb_coef_t i_coef,
	input wire logic i_dual_mode,
	input wire logic i_sample_en,
	output fcb_pkg::fcb_coef_t o_coef,
	output logic o_active
);

	fcb_pkg::fcb_apply_state_t st_reg;
	fcb_pkg::fcb_apply_state_t st_next;

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		st_next = st_reg;
		if (!i_dual_mode) begin
			// outside dual mode the bank drives no taps
			st_next.coef = '0;
			st_next.active = 1'b0;
		end else if (i_sample_en) begin
			// whole set taken at a sample boundary
			st_next.coef = i_coef;
			st_next.active = 1'b1;
		end
		if (i_sys_rst) begin
			st_next = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		st_reg <= st_next;
	end

	assign o_coef = st_reg.coef;
	assign o_active = st_reg.active;

endmodule

// ---- verilog/fcb_bank.sv ----
// channel b equalizer coefficient bank, taps three to eight
`timescale 1ns/100ps
// How it works
// - side taps: signed 12-bit value in 11:0
// - bits 15:12 stored, read back, never filtered
// - centre register 24 bits, 18-bit coefficient
// - nine taps, fifth is the wide centre
// - lowest register tap three, 0x44E tap four
// - registers after centre feed taps six-eight
// - register after tap three feeds tap four
// - coefficients applied only in dual mode
// - tap four 0x44E, centre 0x450, reset zero
// - taps six-eight at 0x453/0x455/0x457, reset zero
// - tap three at 0x44C, reset zero
module fcb_bank (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [14:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic i_dual_mode,
	input wire logic i_sample_en,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output fcb_pkg::fcb_coef_t o_coef,
	output logic o_coef_active
);

	// ------------------------------------------------
	// byte addresses of the upper bytes
	// ------------------------------------------------
	localparam logic [14:0] A_T3_HI = fcb_pkg::FCB_ADDR_TAP3 + fcb_pkg::FCB_BYTE_STEP;
	localparam logic [14:0] A_T4_HI = fcb_pkg::FCB_ADDR_TAP4 + fcb_pkg::FCB_BYTE_STEP;
	localparam logic [14:0] A_C_MID = fcb_pkg::FCB_ADDR_CENTRE + fcb_pkg::FCB_BYTE_STEP;
	localparam logic [14:0] A_C_HI = A_C_MID + fcb_pkg::FCB_BYTE_STEP;
	localparam logic [14:0] A_T6_HI = fcb_pkg::FCB_ADDR_TAP6 + fcb_pkg::FCB_BYTE_STEP;
	localparam logic [14:0] A_T7_HI = fcb_pkg::FCB_ADDR_TAP7 + fcb_pkg::FCB_BYTE_STEP;
	localparam logic [14:0] A_T8_HI = fcb_pkg::FCB_ADDR_TAP8 + fcb_pkg::FCB_BYTE_STEP;

	fcb_pkg::fcb_state_t st_reg;
	fcb_pkg::fcb_state_t st_next;
	fcb_pkg::fcb_coef_t coef_live;
	logic [7:0] rd_byte;
	logic rd_hit;

	// ------------------------------------------------
	// read data select
	// ------------------------------------------------
	always_comb begin
		rd_byte = fcb_pkg::FCB_RST_BYTE;
		rd_hit = 1'b1;
		case (i_reg_addr)
			fcb_pkg::FCB_ADDR_TAP3: begin
				rd_byte = st_reg.regs.tap3[7:0];
			end
			A_T3_HI: begin
				rd_byte = st_reg.regs.tap3[15:8];
			end
			fcb_pkg::FCB_ADDR_TAP4: begin
				rd_byte = st_reg.regs.tap4[7:0];
			end
			A_T4_HI: begin
				rd_byte = st_reg.regs.tap4[15:8];
			end
			fcb_pkg::FCB_ADDR_CENTRE: begin
				rd_byte = st_reg.regs.centre[7:0];
			end
			A_C_MID: begin
				rd_byte = st_reg.regs.centre[15:8];
			end
			A_C_HI: begin
				rd_byte = st_reg.regs.centre[23:16];
			end
			fcb_pkg::FCB_ADDR_TAP6: begin
				rd_byte = st_reg.regs.tap6[7:0];
			end
			A_T6_HI: begin
				rd_byte = st_reg.regs.tap6[15:8];
			end
			fcb_pkg::FCB_ADDR_TAP7: begin
				rd_byte = st_reg.regs.tap7[7:0];
			end
			A_T7_HI: begin
				rd_byte = st_reg.regs.tap7[15:8];
			end
			fcb_pkg::FCB_ADDR_TAP8: begin
				rd_byte = st_reg.regs.tap8[7:0];
			end
			A_T8_HI: begin
				rd_byte = st_reg.regs.tap8[15:8];
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------
	// next state: byte writes and read capture
	// ------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		if (i_reg_rd) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_byte;
		end
		if (i_reg_wr) begin
			// each byte lands in its own register only
			case (i_reg_addr)
				fcb_pkg::FCB_ADDR_TAP3: begin
					st_next.regs.tap3[7:0] = i_reg_wdata;
				end
				A_T3_HI: begin
					st_next.regs.tap3[15:8] = i_reg_wdata;
				end
				fcb_pkg::FCB_ADDR_TAP4: begin
					st_next.regs.tap4[7:0] = i_reg_wdata;
				end
				A_T4_HI: begin
					st_next.regs.tap4[15:8] = i_reg_wdata;
				end
				fcb_pkg::FCB_ADDR_CENTRE: begin
					st_next.regs.centre[7:0] = i_reg_wdata;
				end
				A_C_MID: begin
					st_next.regs.centre[15:8] = i_reg_wdata;
				end
				A_C_HI: begin
					st_next.regs.centre[23:16] = i_reg_wdata;
				end
				fcb_pkg::FCB_ADDR_TAP6: begin
					st_next.regs.tap6[7:0] = i_reg_wdata;
				end
				A_T6_HI: begin
					st_next.regs.tap6[15:8] = i_reg_wdata;
				end
				fcb_pkg::FCB_ADDR_TAP7: begin
					st_next.regs.tap7[7:0] = i_reg_wdata;
				end
				A_T7_HI: begin
					st_next.regs.tap7[15:8] = i_reg_wdata;
				end
				fcb_pkg::FCB_ADDR_TAP8: begin
					st_next.regs.tap8[7:0] = i_reg_wdata;
				end
				A_T8_HI: begin
					st_next.regs.tap8[15:8] = i_reg_wdata;
				end
				default: begin
					st_next.regs = st_reg.regs;
				end
			endcase
		end
		if (i_sys_rst) begin
			// all registers clear to zero
			st_next.regs.tap3 = fcb_pkg::FCB_RST_REG16;
			st_next.regs.tap4 = fcb_pkg::FCB_RST_REG16;
			st_next.regs.centre = fcb_pkg::FCB_RST_REG24;
			st_next.regs.tap6 = fcb_pkg::FCB_RST_REG16;
			st_next.regs.tap7 = fcb_pkg::FCB_RST_REG16;
			st_next.regs.tap8 = fcb_pkg::FCB_RST_REG16;
			st_next.rdata = fcb_pkg::FCB_RST_BYTE;
			st_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		st_reg <= st_next;
	end

	// ------------------------------------------------
	// coefficient fields, reserved bits dropped
	// ------------------------------------------------
	always_comb begin
		// ascending addresses map to taps three, four, six-eight
		coef_live.tap3 = st_reg.regs.tap3[fcb_pkg::FCB_TAP_MSB:0];
		coef_live.tap4 = st_reg.regs.tap4[fcb_pkg::FCB_TAP_MSB:0];
		// fifth of nine taps carries the wide field
		coef_live.centre = st_reg.regs.centre[fcb_pkg::FCB_CENTRE_MSB:0];
		coef_live.tap6 = st_reg.regs.tap6[fcb_pkg::FCB_TAP_MSB:0];
		coef_live.tap7 = st_reg.regs.tap7[fcb_pkg::FCB_TAP_MSB:0];
		coef_live.tap8 = st_reg.regs.tap8[fcb_pkg::FCB_TAP_MSB:0];
	end

	// ------------------------------------------------
	// hand-over to the filter datapath
	// ------------------------------------------------
	fcb_coef_apply u_apply (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_coef(coef_live),
		.i_dual_mode(i_dual_mode),
		.i_sample_en(i_sample_en),
		.o_coef(o_coef),
		.o_active(o_coef_active)
	);

	assign o_reg_rdata = st_reg.rdata;
	assign o_reg_rvalid = st_reg.rvalid;

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	chk_tap3_low_write: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == 15'h044C)
		|=> st_reg.regs.tap3[7:0] == $past(i_reg_wdata))
		else $error("tap three low byte not written");

	chk_tap4_field_path: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == 15'h044E) ##1 (i_sample_en && i_dual_mode)
		|=> o_coef.tap4[7:0] == $past(i_reg_wdata, 2))
		else $error("tap four write did not reach filter");

	chk_centre_top_byte: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == 15'h0452)
		|=> st_reg.regs.centre[23:16] == $past(i_reg_wdata))
		else $error("centre top byte not written");

	chk_tap7_readback: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_rd && i_reg_addr == 15'h0455)
		|=> o_reg_rvalid && o_reg_rdata == $past(st_reg.regs.tap7[7:0]))
		else $error("tap seven readback wrong");

	chk_unmapped_zero: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_rd && !rd_hit)
		|=> o_reg_rvalid && o_reg_rdata == fcb_pkg::FCB_RST_BYTE)
		else $error("unmapped read not zero");

	chk_reset_clears: assert property (
		@(posedge i_clk)
		$past(i_sys_rst) |-> (st_reg.regs == '0 && o_coef == '0 && !o_reg_rvalid))
		else $error("bank not zero after reset");

	chk_mode_gate: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		!i_dual_mode |=> (o_coef == '0 && !o_coef_active))
		else $error("coefficients applied outside dual mode");

	chk_centre_apply: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_sample_en && i_dual_mode)
		|=> o_coef.centre == $past(st_reg.regs.centre[17:0]) && o_coef_active)
		else $error("centre tap not applied at sample");

	chk_hold_between: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sample_en && i_dual_mode && $past(i_dual_mode)) |=> $stable(o_coef))
		else $error("coefficients changed between samples");

	chk_reserved_quiet: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == 15'h0458 && i_dual_mode) ##1 (i_sample_en && i_dual_mode)
		|=> o_coef.tap8 == $past(st_reg.regs.tap8[11:0]))
		else $error("reserved bits reached the filter");

	chk_tap6_low_write: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == fcb_pkg::FCB_ADDR_TAP6)
		|=> st_reg.regs.tap6[7:0] == $past(i_reg_wdata))
		else $error("tap six low byte not written");

	chk_tap8_reserved_write: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == A_T8_HI)
		|=> st_reg.regs.tap8[15:12] == $past(i_reg_wdata[7:4]))
		else $error("tap eight reserved bits not stored");

	chk_centre_mid_write: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == A_C_MID)
		|=> st_reg.regs.centre[15:8] == $past(i_reg_wdata))
		else $error("centre middle byte not written");

	chk_tap3_apply: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_sample_en && i_dual_mode)
		|=> o_coef.tap3 == $past(st_reg.regs.tap3[11:0]))
		else $error("tap three not applied at sample");

	chk_tap4_apply: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_sample_en && i_dual_mode)
		|=> o_coef.tap4 == $past(st_reg.regs.tap4[11:0]))
		else $error("tap four not applied at sample");

	chk_tap8_apply: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_sample_en && i_dual_mode)
		|=> o_coef.tap8 == $past(st_reg.regs.tap8[11:0]))
		else $error("tap eight not applied at sample");

	chk_write_isolated: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && i_reg_addr == fcb_pkg::FCB_ADDR_TAP3)
		|=> st_reg.regs.tap4 == $past(st_reg.regs.tap4))
		else $error("write to tap three disturbed tap four");

endmodule

// ---- testbench/fcb_bank_tb.sv ----
// self-checking bench for the channel b equalizer coefficient bank
`timescale 1ns/100ps
module testbench;
	logic i_clk;
	logic i_sys_rst;
	logic [14:0] i_reg_addr;
	logic [7:0] i_reg_wdata;
	logic i_reg_wr;
	logic i_reg_rd;
	logic i_dual_mode;
	logic i_sample_en;
	logic [7:0] o_reg_rdata;
	logic o_reg_rvalid;
	fcb_pkg::fcb_coef_t o_coef;
	logic o_coef_active;
	logic [14:0] base [6];
	int nb [6];
	logic [23:0] shadow [6];
	int errors;
	int tests_run;

	fcb_bank DUT (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd),
		.i_dual_mode(i_dual_mode),
		.i_sample_en(i_sample_en),
		.o_reg_rdata(o_reg_rdata),
		.o_reg_rvalid(o_reg_rvalid),
		.o_coef(o_coef),
		.o_coef_active(o_coef_active)
	);

	// ------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	initial begin
		#(25 * 4000);
		errors++;
		conclude();
	end

	// ------------------------------------------------
	// compare tasks
	// ------------------------------------------------
	task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk1(input string name, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %b seen %b", name, e, g);
		end
	endtask

	task automatic chk_coef(input fcb_pkg::fcb_coef_t e);
		tests_run++;
		if (o_coef !== e) begin
			errors++;
			$display("FAIL o_coef expected %h seen %h", e, o_coef);
		end
	endtask

	function automatic fcb_pkg::fcb_coef_t coef_of();
		coef_of = {shadow[0][11:0], shadow[1][11:0], shadow[2][17:0],
			shadow[3][11:0], shadow[4][11:0], shadow[5][11:0]};
	endfunction

	// ------------------------------------------------
	// register port tasks
	// ------------------------------------------------
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_clk);
		i_reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(negedge i_clk);
		i_reg_rd = 1'b0;
		chk1("o_reg_rvalid", 1'b1, o_reg_rvalid);
		chk8("o_reg_rdata", e, o_reg_rdata);
	endtask

	task automatic wreg(input int i, input logic [23:0] v);
		shadow[i] = v;
		for (int b = 0; b < nb[i]; b++) begin
			wr(base[i] + 15'(b), v[8*b +: 8]);
		end
	endtask

	task automatic rreg(input int i);
		for (int b = 0; b < nb[i]; b++) begin
			rd(base[i] + 15'(b), shadow[i][8*b +: 8]);
		end
	endtask

	task automatic sample(input logic dual);
		@(negedge i_clk);
		i_dual_mode = dual;
		i_sample_en = 1'b1;
		@(negedge i_clk);
		i_sample_en = 1'b0;
	endtask

	// one byte written, sample on the very next edge
	task automatic wr_sample(input int i, input int b, input logic [7:0] d);
		shadow[i][8*b +: 8] = d;
		@(negedge i_clk);
		i_reg_addr = base[i] + 15'(b);
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		i_dual_mode = 1'b1;
		@(negedge i_clk);
		i_reg_wr = 1'b0;
		i_sample_en = 1'b1;
		@(negedge i_clk);
		i_sample_en = 1'b0;
	endtask

	task automatic do_reset();
		@(negedge i_clk);
		i_sys_rst = 1'b1;
		repeat (20) @(negedge i_clk);
		i_sys_rst = 1'b0;
		for (int i = 0; i < 6; i++) begin
			shadow[i] = 24'h00_0000;
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ------------------------------------------------
	// test sequence
	// ------------------------------------------------
	initial begin
		i_sys_rst = 1'b1;
		i_reg_addr = 15'h0000;
		i_reg_wdata = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_dual_mode = 1'b0;
		i_sample_en = 1'b0;
		errors = 0;
		tests_run = 0;
		base = '{fcb_pkg::FCB_ADDR_TAP3, fcb_pkg::FCB_ADDR_TAP4, fcb_pkg::FCB_ADDR_CENTRE,
			fcb_pkg::FCB_ADDR_TAP6, fcb_pkg::FCB_ADDR_TAP7, fcb_pkg::FCB_ADDR_TAP8};
		nb = '{2, 2, 3, 2, 2, 2};
		do_reset();
		// reset values of every byte
		for (int i = 0; i < 6; i++) begin
			rreg(i);
		end
		chk_coef('0);
		chk1("o_coef_active", 1'b0, o_coef_active);
		$display("test reset_values done");
		// full write and read back, reserved bits included
		wreg(0, 24'h00_A123);
		wreg(1, 24'h00_5F80);
		wreg(2, 24'hFE_8001);
		wreg(3, 24'h00_3ABC);
		wreg(4, 24'h00_C800);
		wreg(5, 24'h00_7FFF);
		for (int i = 0; i < 6; i++) begin
			rreg(i);
		end
		wr(15'h0459, 8'hFF);
		rd(15'h0459, 8'h00);
		rd(15'h044B, 8'h00);
		$display("test readback done");
		// sample in dual mode: fields only, reserved stripped
		sample(1'b1);
		chk_coef(coef_of());
		chk1("o_coef_active", 1'b1, o_coef_active);
		$display("test dual_sample done");
		// one tap rewritten: held until next sample, others untouched
		begin
			fcb_pkg::fcb_coef_t old_coef;
			old_coef = coef_of();
			wreg(4, 24'h00_0801);
			chk_coef(old_coef);
		end
		sample(1'b1);
		chk_coef(coef_of());
		rreg(3);
		$display("test tap_update done");
		// write followed at once by a sample
		wr_sample(1, 0, 8'hC7);
		chk_coef(coef_of());
		wr_sample(5, 1, 8'h9A);
		chk_coef(coef_of());
		rreg(5);
		$display("test write_then_sample done");
		// leaving dual mode clears the applied set
		@(negedge i_clk);
		i_dual_mode = 1'b0;
		@(negedge i_clk);
		chk_coef('0);
		chk1("o_coef_active", 1'b0, o_coef_active);
		sample(1'b0);
		chk_coef('0);
		$display("test single_mode done");
		// second reset in mid-run, with a set applied
		sample(1'b1);
		chk1("o_coef_active", 1'b1, o_coef_active);
		do_reset();
		chk_coef('0);
		chk1("o_coef_active", 1'b0, o_coef_active);
		for (int i = 0; i < 6; i++) begin
			rreg(i);
		end
		$display("test second_reset done");
		conclude();
	end
endmodule
